// ==== usmrc_pkg.sv ====
// Constants and types for the strap, modem and reset pin controller.
// Assumes one 20 MHz system clock and no register bus; all control is on ports.
//=====================================================================
package usmrc_pkg;
    //=================================================================
    // Timing
    localparam int CLK_HZ         = 20_000_000;
    localparam int CLK_PERIOD_NS  = 50;
    localparam int SCL_MAX_HZ     = 400_000;
    // Half period rounds up so the clock never exceeds the limit
    localparam int SCL_HALF_CYC   = (CLK_HZ + 2 * SCL_MAX_HZ - 1) / (2 * SCL_MAX_HZ);
    localparam int RST_MIN_NS     = 40;
    localparam int RST_MIN_CYC    = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES    = 2;
    localparam int RADIO_RST_CYC  = 16;
    //=================================================================
    // Reset values
    localparam logic RTS_N_RST    = 1'b1;
    localparam logic DTR_N_RST    = 1'b1;
    localparam logic TX_IDLE      = 1'b1;
    localparam logic RADIO_RST_ON = 1'b1;
    //=================================================================
    // Strap decodes
    typedef enum logic [0:0] {
        USMRC_HOST_PAR = 1'b0,
        USMRC_HOST_SER = 1'b1
    } usmrc_host_t;
    typedef enum logic [0:0] {
        USMRC_BUS_RW     = 1'b0,
        USMRC_BUS_STROBE = 1'b1
    } usmrc_bus_t;
    // Sequencer states after reset release
    typedef enum logic [1:0] {
        USMRC_ST_RESET = 2'b00,
        USMRC_ST_RADIO = 2'b01,
        USMRC_ST_RUN   = 2'b10
    } usmrc_state_t;
endpackage

// ==== usmrc_sync.sv ====
// Two-flop synchroniser bank for asynchronous pins.
// Assumes the first stage is read only by the second.
`timescale 1ns/1ps
module usmrc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             clock_i,  // System clock
    input  wire logic             arst_n_i, // Async reset, active low
    input  wire logic [WIDTH-1:0] d_i,      // Asynchronous inputs
    output logic      [WIDTH-1:0] q_o       // Synchronised outputs
);
    logic [WIDTH-1:0] meta_ff;
    //=================================================================
    // Double flop chain
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_ff <= INIT;
            q_o     <= INIT;
        end else begin
            meta_ff <= d_i;
            q_o     <= meta_ff;
        end
    end
endmodule

// ==== usmrc_top.sv ====
// Strap, modem handshake, reset and radio sideband control.
// Assumes clock_i at 20 MHz; pins arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
module usmrc_top (
    input  wire logic clock_i,               // System clock 20 MHz
    input  wire logic arst_n_i,              // Power-on reset, active low
    input  wire logic reset_pin_i,           // Host reset pin, polarity from bus strap
    input  wire logic host_serial_sel_i,     // Strap: high serial, low parallel
    input  wire logic bus_strobe_sel_i,      // Strap: high strobe style, low rw line
    input  wire logic rts_ctrl_i,            // Software request-to-send level
    input  wire logic dtr_ctrl_i,            // Software terminal-ready level
    input  wire logic auto_cts_en_i,         // Auto clear-to-send gating enable
    input  wire logic host_irq_en_i,         // Modem control interrupt output enable, strobe style only; rw style drives on request
    input  wire logic host_irq_req_i,        // Internal interrupt request
    input  wire logic tx_data_i,             // Serial transmit data from core
    input  wire logic tx_req_i,              // Core asks to start a character
    input  wire logic cts_n_i,               // Clear-to-send pin, active low
    input  wire logic dsr_n_i,               // Data-set-ready pin, active low
    input  wire logic carrier_detect_n_i,    // Carrier detect pin, active low
    input  wire logic ring_indicate_n_i,     // Ring indicate pin, active low
    input  wire logic rx_pin_i,              // Serial receive pin
    input  wire logic radio_irq_n_i,         // Radio interrupt pin, active low
    input  wire logic radio_data_in_i,       // Radio direct data in
    input  wire logic radio_direct_data_en_i,// Direct data path enable
    input  wire logic radio_tx_data_i,       // Data for the radio direct path
    input  wire logic scl_i,                 // Two-wire clock line level
    output logic      rts_n_o,               // Request-to-send pin
    output logic      dtr_n_o,               // Terminal-ready pin
    output logic      tx_pin_o,              // Serial transmit pin
    output logic      tx_allow_o,            // Transmit permitted by flow control
    output logic      rx_data_o,             // Receive data to core, idle high
    output logic      dsr_o,                 // Data set ready, active high
    output logic      carrier_o,             // Carrier detect, active high
    output logic      ring_o,                // Ring indicate, active high
    output logic      radio_reset_o,         // Reset to radio transceiver
    output logic      radio_irq_o,           // Radio interrupt, active high
    output logic      radio_data_out_o,      // Radio direct data out
    output logic      radio_rx_data_o,       // Data received on direct path
    output logic      scl_o,                 // Two-wire clock output value
    output logic      scl_oe_o,              // Two-wire clock drive enable
    output logic      host_irq_o,            // Host interrupt output value
    output logic      host_irq_oe_o,         // Host interrupt drive enable
    output logic      host_serial_o,         // Latched strap: serial host port
    output logic      bus_strobe_o,          // Latched strap: strobe style
    output logic      core_run_o             // Internal state machines released
);
    import usmrc_pkg::*;

    //=================================================================
    // Pin synchronisers
    logic [11:0] pins_s;
    usmrc_sync #(
        .WIDTH (12),
        .INIT  (12'hFFF)
    ) u_sync (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .d_i      ({reset_pin_i, host_serial_sel_i, bus_strobe_sel_i, cts_n_i, dsr_n_i,
                    carrier_detect_n_i, ring_indicate_n_i, rx_pin_i, radio_irq_n_i,
                    radio_data_in_i, radio_direct_data_en_i, scl_i}),
        .q_o      (pins_s)
    );
    logic rst_pin_s, ser_s, strb_s, cts_n_s, dsr_n_s, cd_n_s, ri_n_s;
    logic rx_s, rirq_n_s, rdi_s, rden_s, scl_s;
    assign {rst_pin_s, ser_s, strb_s, cts_n_s, dsr_n_s, cd_n_s, ri_n_s,
            rx_s, rirq_n_s, rdi_s, rden_s, scl_s} = pins_s;

    //=================================================================
    // Strap capture while reset is held
    logic         ser_ff;
    logic         strb_ff;
    logic         strap_done_ff;
    logic [1:0]   strap_cnt_ff;
    // Straps are taken only once the synchronisers hold pin levels, not their reset fill
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ser_ff        <= 1'b0;
            strb_ff       <= 1'b1;
            strap_cnt_ff  <= 2'h0;
            strap_done_ff <= 1'b0;
        end else if (!strap_done_ff) begin
            strap_cnt_ff <= strap_cnt_ff + 2'h1;
            if (strap_cnt_ff == 2'(SYNC_STAGES)) begin
                ser_ff        <= ser_s;
                strb_ff       <= strb_s;
                strap_done_ff <= 1'b1;
            end
        end
    end

    //=================================================================
    // Reset pin decode by bus style, with minimum width filter
    logic       rst_active;
    logic [3:0] rst_cnt_ff;
    logic       host_rst_ff;
    assign rst_active = (strb_ff == USMRC_BUS_STROBE) ? rst_pin_s : !rst_pin_s;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_cnt_ff  <= 4'h0;
            host_rst_ff <= 1'b1;
        end else if (!strap_done_ff) begin
            host_rst_ff <= 1'b1;
        end else if (rst_active) begin
            if (rst_cnt_ff < 4'(RST_MIN_CYC)) begin
                rst_cnt_ff <= rst_cnt_ff + 4'h1;
            end
            if (rst_cnt_ff + 4'h1 >= 4'(RST_MIN_CYC)) begin
                host_rst_ff <= 1'b1;
            end
        end else begin
            rst_cnt_ff  <= 4'h0;
            host_rst_ff <= 1'b0;
        end
    end

    //=================================================================
    // Release sequencer: radio reset pulse then run
    usmrc_state_t state_ff;
    logic [4:0]   seq_cnt_ff;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff   <= USMRC_ST_RESET;
            seq_cnt_ff <= 5'h00;
        end else if (host_rst_ff) begin
            state_ff   <= USMRC_ST_RESET;
            seq_cnt_ff <= 5'h00;
        end else begin
            case (state_ff)
                USMRC_ST_RESET: begin
                    state_ff <= USMRC_ST_RADIO;
                end
                USMRC_ST_RADIO: begin
                    seq_cnt_ff <= seq_cnt_ff + 5'h01;
                    if (seq_cnt_ff == 5'(RADIO_RST_CYC - 1)) begin
                        state_ff <= USMRC_ST_RUN;
                    end
                end
                USMRC_ST_RUN: begin
                    state_ff <= USMRC_ST_RUN;
                end
                default: begin
                    state_ff <= USMRC_ST_RESET;
                end
            endcase
        end
    end
    logic run;
    assign run = (state_ff == USMRC_ST_RUN);

    //=================================================================
    // Modem handshake outputs and inputs
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rts_n_o    <= RTS_N_RST;
            dtr_n_o    <= DTR_N_RST;
            tx_allow_o <= 1'b0;
            dsr_o      <= 1'b0;
            carrier_o  <= 1'b0;
            ring_o     <= 1'b0;
        end else if (!run) begin
            rts_n_o    <= RTS_N_RST;
            dtr_n_o    <= DTR_N_RST;
            tx_allow_o <= 1'b0;
            dsr_o      <= 1'b0;
            carrier_o  <= 1'b0;
            ring_o     <= 1'b0;
        end else begin
            rts_n_o    <= !rts_ctrl_i;
            dtr_n_o    <= !dtr_ctrl_i;
            tx_allow_o <= !auto_cts_en_i || !cts_n_s;
            dsr_o      <= !dsr_n_s;
            carrier_o  <= !cd_n_s;
            ring_o     <= !ri_n_s;
        end
    end

    //=================================================================
    // Host serial data path
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_pin_o  <= TX_IDLE;
            rx_data_o <= 1'b1;
        end else if (!run) begin
            tx_pin_o  <= TX_IDLE;
            rx_data_o <= 1'b1;
        end else begin
            tx_pin_o  <= (tx_req_i && !tx_allow_o) ? TX_IDLE : tx_data_i;
            rx_data_o <= rx_s;
        end
    end

    //=================================================================
    // Radio sideband
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            radio_reset_o    <= RADIO_RST_ON;
            radio_irq_o      <= 1'b0;
            radio_data_out_o <= 1'b1;
            radio_rx_data_o  <= 1'b1;
        end else begin
            radio_reset_o    <= !run;
            radio_irq_o      <= run && !rirq_n_s;
            radio_data_out_o <= (run && rden_s) ? radio_tx_data_i : 1'b1;
            radio_rx_data_o  <= (run && rden_s) ? rdi_s : 1'b1;
        end
    end

    //=================================================================
    // Two-wire clock divider, open drain
    logic [5:0] scl_cnt_ff;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_cnt_ff <= 6'h00;
            scl_oe_o   <= 1'b0;
            // Line value is only ever low; the enable alone makes it open drain
            scl_o      <= 1'b0;
        end else if (!run || rden_s) begin
            scl_cnt_ff <= 6'h00;
            scl_oe_o   <= 1'b0;
        end else if (scl_cnt_ff == 6'(SCL_HALF_CYC - 1)) begin
            scl_cnt_ff <= 6'h00;
            scl_oe_o   <= !scl_oe_o;
        end else begin
            scl_cnt_ff <= scl_cnt_ff + 6'h01;
        end
    end

    //=================================================================
    // Host interrupt pin style and strap status
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            host_irq_o    <= 1'b0;
            host_irq_oe_o <= 1'b0;
            host_serial_o <= 1'b0;
            bus_strobe_o  <= 1'b1;
            core_run_o    <= 1'b0;
        end else begin
            host_serial_o <= ser_ff;
            bus_strobe_o  <= strb_ff;
            core_run_o    <= run;
            if (!run) begin
                host_irq_o    <= 1'b0;
                host_irq_oe_o <= 1'b0;
            end else if (strb_ff == USMRC_BUS_STROBE) begin
                host_irq_o    <= host_irq_req_i;
                host_irq_oe_o <= host_irq_en_i;
            end else begin
                host_irq_o    <= 1'b0;
                host_irq_oe_o <= host_irq_req_i;
            end
        end
    end

    //=================================================================
    // Checks
    logic scl_prev_oe;
    assign scl_prev_oe = scl_oe_o;
    // Startup, reset pin and reset period behaviour
    strap_before_run_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        run |-> strap_done_ff) else $error("run before straps latched");
    tx_idle_reset_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        host_rst_ff |=> ##1 tx_pin_o) else $error("tx not idle in reset");
    rx_ignore_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        !run |=> rx_data_o) else $error("rx not ignored in reset");
    radio_rst_run_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        run |=> !radio_reset_o) else $error("radio reset with run");
    radio_rst_hold_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        !run |=> radio_reset_o) else $error("radio reset dropped early");
    rst_width_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (strap_done_ff && rst_active) [*2] |=> host_rst_ff) else $error("reset not taken");
    rst_polarity_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        strap_done_ff && !strb_ff && !rst_pin_s |-> rst_active) else $error("rw style polarity");
    // Clock phases are long enough; a stop by reset or direct path may cut the low phase
    scl_rate_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        $rose(scl_oe_o) |=> (scl_oe_o || !run || rden_s) [*8]) else $error("scl low phase too short");
    scl_high_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        $fell(scl_oe_o) |=> (!scl_oe_o) [*8]) else $error("scl high phase too short");
    // Modem handshake lines
    cts_gate_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        run && auto_cts_en_i && cts_n_s ##1 run |-> !tx_allow_o) else $error("cts gate open");
    rts_level_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        run |=> rts_n_o == !$past(rts_ctrl_i)) else $error("rts not inverted");
    dtr_level_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        run |=> dtr_n_o == !$past(dtr_ctrl_i)) else $error("dtr not inverted");
    dsr_copy_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        run |=> dsr_o == !$past(dsr_n_s)) else $error("dsr not copied");
    // Radio sideband and host interrupt styles
    radio_irq_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        run |=> radio_irq_o == !$past(rirq_n_s)) else $error("radio irq not copied");
    direct_idle_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        !rden_s |=> radio_data_out_o) else $error("direct data out not idle");
    direct_path_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        run && rden_s |=> radio_data_out_o == $past(radio_tx_data_i)) else $error("direct data not passed");
    irq_tristate_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        run && strb_ff && !host_irq_en_i |=> !host_irq_oe_o) else $error("irq driven");
    irq_open_drain_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        run && !strb_ff |=> !host_irq_o && host_irq_oe_o == $past(host_irq_req_i)) else $error("rw irq style");
    // Main scenarios reached
    cover_run_c:    cover property (@(posedge clock_i) disable iff (!arst_n_i) $rose(run));
    cover_rst_c:    cover property (@(posedge clock_i) disable iff (!arst_n_i) run ##1 host_rst_ff);
    cover_scl_c:    cover property (@(posedge clock_i) disable iff (!arst_n_i) $fell(scl_prev_oe));
    cover_direct_c: cover property (@(posedge clock_i) disable iff (!arst_n_i) run && rden_s);
    cover_od_c:     cover property (@(posedge clock_i) disable iff (!arst_n_i) run && !strb_ff && host_irq_oe_o);
endmodule

// ==== usmrc_partner.sv ====
// Far-side model: modem lines of the host port and the radio transceiver pins.
// Assumes the bench changes the request levels just after a falling clock edge.
`timescale 1ns/1ps
module usmrc_partner (
    input  wire logic clock_i,         // System clock
    input  wire logic cts_on_i,        // Far side grants clear-to-send
    input  wire logic dsr_on_i,        // Far side data set ready
    input  wire logic cd_on_i,         // Far side carrier present
    input  wire logic ri_on_i,         // Far side ringing
    input  wire logic irq_on_i,        // Radio raises its interrupt
    input  wire logic rx_val_i,        // Serial line level sent to the device
    input  wire logic di_val_i,        // Radio direct data level
    input  wire logic direct_en_i,     // Direct data path in use
    input  wire logic scl_oe_i,        // Device pulls the clock line low
    output logic      cts_n_o,         // Clear-to-send pin
    output logic      dsr_n_o,         // Data-set-ready pin
    output logic      cd_n_o,          // Carrier pin
    output logic      ri_n_o,          // Ring pin
    output logic      rx_pin_o,        // Serial receive line
    output logic      radio_irq_n_o,   // Radio interrupt pin
    output logic      radio_data_in_o, // Radio direct data line
    output logic      scl_o            // Clock line level
);
    logic stir_ff = 1'b0;
    //=================================================================
    // Modem lines
    // Asserted lines are driven low
    assign cts_n_o = ~cts_on_i;
    assign dsr_n_o = ~dsr_on_i;
    assign cd_n_o  = ~cd_on_i;
    assign ri_n_o  = ~ri_on_i;
    assign rx_pin_o = rx_val_i;
    //=================================================================
    // Radio side
    // Pattern that moves every cycle on a line nobody is using
    always @(negedge clock_i) begin
        stir_ff <= ~stir_ff;
    end
    assign radio_irq_n_o   = ~irq_on_i;
    assign radio_data_in_o = direct_en_i ? di_val_i : stir_ff;
    // Clock line has a pull-up, the device only pulls it low
    assign scl_o = scl_oe_i ? 1'b0 : 1'b1;
endmodule

// ==== usmrc_tb_top.sv ====
// Self-checking bench for the strap, modem and reset pin controller.
// Assumes a 20 MHz clock; the far side is the partner model.
`timescale 1ns/1ps
module usmrc_tb_top;
    import usmrc_pkg::*;
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0, reset_pin_i = 1'b0, host_serial_sel_i = 1'b0, bus_strobe_sel_i = 1'b0;
    logic rts_ctrl_i = 1'b0, dtr_ctrl_i = 1'b0, auto_cts_en_i = 1'b0, host_irq_en_i = 1'b0;
    logic host_irq_req_i = 1'b0, tx_data_i = 1'b0, tx_req_i = 1'b0, radio_direct_data_en_i = 1'b0;
    logic radio_tx_data_i = 1'b0, cts_on = 1'b0, dsr_on = 1'b0, cd_on = 1'b0, ri_on = 1'b0;
    logic irq_on = 1'b0, rx_val = 1'b1, di_val = 1'b0;
    logic cts_n_i, dsr_n_i, carrier_detect_n_i, ring_indicate_n_i, rx_pin_i, radio_irq_n_i;
    logic radio_data_in_i, scl_i, rts_n_o, dtr_n_o, tx_pin_o, tx_allow_o, rx_data_o, dsr_o;
    logic carrier_o, ring_o, radio_reset_o, radio_irq_o, radio_data_out_o, radio_rx_data_o;
    logic scl_o, scl_oe_o, host_irq_o, host_irq_oe_o, host_serial_o, bus_strobe_o, core_run_o;
    int   fail_count = 0, check_count = 0, cyc = 0, k, len;
    //=================================================================
    // Design and far side
    usmrc_top dut_u (.clock_i, .arst_n_i, .reset_pin_i, .host_serial_sel_i, .bus_strobe_sel_i,
        .rts_ctrl_i, .dtr_ctrl_i, .auto_cts_en_i, .host_irq_en_i, .host_irq_req_i, .tx_data_i,
        .tx_req_i, .cts_n_i, .dsr_n_i, .carrier_detect_n_i, .ring_indicate_n_i, .rx_pin_i,
        .radio_irq_n_i, .radio_data_in_i, .radio_direct_data_en_i, .radio_tx_data_i, .scl_i,
        .rts_n_o, .dtr_n_o, .tx_pin_o, .tx_allow_o, .rx_data_o, .dsr_o, .carrier_o, .ring_o,
        .radio_reset_o, .radio_irq_o, .radio_data_out_o, .radio_rx_data_o, .scl_o, .scl_oe_o,
        .host_irq_o, .host_irq_oe_o, .host_serial_o, .bus_strobe_o, .core_run_o);
    usmrc_partner far_u (.clock_i, .cts_on_i(cts_on), .dsr_on_i(dsr_on), .cd_on_i(cd_on),
        .ri_on_i(ri_on), .irq_on_i(irq_on), .rx_val_i(rx_val), .di_val_i(di_val),
        .direct_en_i(radio_direct_data_en_i), .scl_oe_i(scl_oe_o), .cts_n_o(cts_n_i),
        .dsr_n_o(dsr_n_i), .cd_n_o(carrier_detect_n_i), .ri_n_o(ring_indicate_n_i),
        .rx_pin_o(rx_pin_i), .radio_irq_n_o(radio_irq_n_i), .radio_data_in_o(radio_data_in_i),
        .scl_o(scl_i));
    //=================================================================
    // Clock and hang guard
    initial begin
        forever #25 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            conclude();
        end
    end
    //=================================================================
    // Shared tasks
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_int(input string what, input int exp, input int got);
        check_count++;
        if (got != exp) begin
            fail_count++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    // Outputs held at reset values; software levels and rx are set to show otherwise
    task automatic check_idle;
        cycles(1);
        check_bit("core_run_o", 1'b0, core_run_o);
        check_bit("rts_n_o", 1'b1, rts_n_o);
        check_bit("dtr_n_o", 1'b1, dtr_n_o);
        check_bit("tx_pin_o", 1'b1, tx_pin_o);
        check_bit("rx_data_o", 1'b1, rx_data_o);
        check_bit("radio_reset_o", 1'b1, radio_reset_o);
    endtask
    // Radio reset holds through the sequencer, then the core runs
    task automatic wait_run;
        int n;
        n = 0;
        cycles(15);
        check_bit("radio_reset_o", 1'b1, radio_reset_o);
        while (core_run_o !== 1'b1 && n < 40) begin
            cycles(1);
            n++;
        end
        cycles(1);
        check_bit("core_run_o", 1'b1, core_run_o);
        check_bit("radio_reset_o", 1'b0, radio_reset_o);
    endtask
    task automatic measure_scl(output int n);
        logic last;
        n = 0;
        last = scl_oe_o;
        while (scl_oe_o === last && n < 60) begin
            cycles(1);
            n++;
        end
        last = scl_oe_o;
        n = 0;
        while (scl_oe_o === last && n < 60) begin
            cycles(1);
            n++;
        end
    endtask
    //=================================================================
    // Main sequence
    initial begin
        for (k = 0; k < 4; k++) begin
            @(negedge clock_i);
            arst_n_i = 1'b0;
            host_serial_sel_i = k[1];
            bus_strobe_sel_i = k[0];
            reset_pin_i = ~k[0];
            rx_val = 1'b0;
            rts_ctrl_i = 1'b1;
            dtr_ctrl_i = 1'b1;
            tx_req_i = 1'b1;
            cycles(1);
            check_idle();
            arst_n_i = 1'b1;
            wait_run();
            check_bit("host_serial_o", k[1], host_serial_o);
            check_bit("bus_strobe_o", k[0], bus_strobe_o);
            check_bit("rx_data_o", 1'b0, rx_data_o);
            // Interrupt output per bus style, req in bit 0 and enable in bit 1
            for (int r = 0; r < 4; r++) begin
                host_irq_req_i = r[0];
                host_irq_en_i = r[1];
                cycles(2);
                check_bit("host_irq_oe_o", k[0] ? r[1] : r[0], host_irq_oe_o);
                if (k[0] ? r[1] : r[0]) check_bit("host_irq_o", k[0] & r[0], host_irq_o);
            end
            // One cycle pulse at the active level of this style
            reset_pin_i = k[0];
            cycles(1);
            reset_pin_i = ~k[0];
            for (int n = 0; n < 8 && core_run_o !== 1'b0; n++) cycles(1);
            check_idle();
            wait_run();
            rx_val = 1'b1;
        end
        // Active low modem outputs follow software levels
        for (k = 0; k < 4; k++) begin
            rts_ctrl_i = k[0];
            dtr_ctrl_i = k[1];
            cycles(2);
            check_bit("rts_n_o", ~k[0], rts_n_o);
            check_bit("dtr_n_o", ~k[1], dtr_n_o);
        end
        // Clear-to-send gating; transmit data is low so a held line shows as high
        for (k = 0; k < 4; k++) begin
            auto_cts_en_i = k[1];
            cts_on = k[0];
            cycles(4);
            check_bit("tx_allow_o", ~k[1] | k[0], tx_allow_o);
            check_bit("tx_pin_o", k[1] & ~k[0], tx_pin_o);
        end
        // Other modem inputs are copied and leave the transmitter blocked
        cts_on = 1'b0;
        for (k = 0; k < 8; k++) begin
            dsr_on = k[0];
            cd_on = k[1];
            ri_on = k[2];
            cycles(4);
            check_bit("dsr_o", k[0], dsr_o);
            check_bit("carrier_o", k[1], carrier_o);
            check_bit("ring_o", k[2], ring_o);
            check_bit("tx_allow_o", 1'b0, tx_allow_o);
        end
        // Radio interrupt and direct data path
        for (k = 0; k < 4; k++) begin
            irq_on = k[0];
            di_val = k[0];
            radio_tx_data_i = ~k[0];
            radio_direct_data_en_i = k[1];
            cycles(4);
            check_bit("radio_irq_o", k[0], radio_irq_o);
            check_bit("radio_data_out_o", k[1] ? ~k[0] : 1'b1, radio_data_out_o);
            check_bit("radio_rx_data_o", k[1] ? k[0] : 1'b1, radio_rx_data_o);
        end
        // Two-wire clock half period while the direct path is off
        radio_direct_data_en_i = 1'b0;
        cycles(4);
        measure_scl(len);
        check_int("scl half period", SCL_HALF_CYC, len);
        check_bit("scl_o", 1'b0, scl_o);
        conclude();
    end
endmodule
